// ### verilog/phy_regs_map.svh
// Operation
// - Window holds address when function is 00
// - Function picks address, data, increment modes
// - Capability register reads fixed gigabit flags
// - Fast status shows live lock and link
// - Fast error flags latch, clear on read
// - Gigabit status shows live lock and link
// - Gigabit error flags latch, clear on read
// - Legacy partner and crossover error indicators
// - Bit 15 disables transmitter
// - Bits 14..10 bypass coding and PCS paths
// - Bit 9 bypasses link fail inhibit timer
// - Bit 7 disables crossover at forced speed
// - Bit 6 disables legacy partner detection
// - Bits 5,4 disable pair swap, polarity
// - Bit 3 selects parallel detect behaviour
// - Bit 2 disables pulse shaping filter
// - Bit 1 stops automatic next page exchange
// - Receive error counter saturates, clears on read
// - False carrier counter saturates, clears on read
// - Link drop counter saturates, clears on read
// - Sticky bits survive soft reset when enabled
`ifndef PHY_REGS_MAP_SVH
`define PHY_REGS_MAP_SVH
`define ADDR_WINDOW 5'h0E
`define ADDR_GIG_CAP 5'h0F
`define ADDR_FAST_STAT 5'h10
`define ADDR_GIG_STAT 5'h11
`define ADDR_BYPASS 5'h12
`define ADDR_RX_ERR_CNT 5'h13
`define ADDR_FALSE_CAR_CNT 5'h14
`define ADDR_LINK_DROP_CNT 5'h15
`define GIG_CAP_VALUE 16'h3000
`define BYPASS_WMASK 16'hFEFE
`define BYPASS_STICKY_MASK 16'h00FA
`define BYPASS_RESET 16'h0088
`define FAST_LOCK_BIT 15
`define FAST_LINK_BIT 12
`define GIG_LOCK_BIT 15
`define GIG_LINK_BIT 12
`define GIG_LEGACY_BIT 6
`define GIG_XOVER_BIT 5
`define CNT_MAX 8'hFF
`endif

// ### verilog/phy_regs_pkg.sv
`default_nettype none
package phy_regs_pkg;
   typedef enum logic [1:0] {
      FN_ADDRESS = 2'h0,
      FN_DATA = 2'h1,
      FN_DATA_INC_RW = 2'h2,
      FN_DATA_INC_W = 2'h3
   } mmd_function_t;
endpackage : phy_regs_pkg
`default_nettype wire

// ### verilog/sat_read_counter.sv
`default_nettype none
`include "phy_regs_map.svh"
module sat_read_counter
   import phy_regs_pkg::*;
(
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic event_i,
   input wire logic read_clear_i,
   output logic [7:0] count_o
);
   logic [7:0] count_r;
   logic [7:0] count_nxt;
   always_comb
   begin
      count_nxt = count_r;
      // Event during the clearing read counts as one
      if (read_clear_i)
         count_nxt = event_i ? 8'h01 : 8'h00;
      else if (event_i && count_r != `CNT_MAX)
         count_nxt = count_r + 8'h01;
   end
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
         count_r <= 8'h00;
      else
         count_r <= count_nxt;
   end
   assign count_o = count_r;
endmodule : sat_read_counter
`default_nettype wire

// ### verilog/phy_status_bypass_counter_regs.sv
`default_nettype none
`include "phy_regs_map.svh"
module phy_status_bypass_counter_regs
   import phy_regs_pkg::*;
(
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic soft_reset_i,
   input wire logic sticky_reset_enable_i,
   input wire logic [4:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [15:0] reg_wdata_i,
   output logic [15:0] reg_rdata_o,
   input wire logic [1:0] mmd_function_i,
   input wire logic [4:0] mmd_device_select_i,
   output logic mmd_wr_o,
   output logic mmd_rd_o,
   output logic [4:0] mmd_dev_o,
   output logic [15:0] mmd_addr_o,
   output logic [15:0] mmd_wdata_o,
   input wire logic [15:0] mmd_rdata_i,
   input wire logic fast_lock_i,
   input wire logic fast_link_i,
   input wire logic [5:0] fast_events_i,
   input wire logic gig_lock_i,
   input wire logic gig_link_i,
   input wire logic [6:0] gig_events_i,
   input wire logic legacy_partner_i,
   input wire logic crossover_error_i,
   input wire logic rx_error_i,
   input wire logic false_carrier_i,
   input wire logic link_drop_i,
   output logic transmit_disable_o,
   output logic [4:0] path_bypass_o,
   output logic link_fail_inhibit_bypass_o,
   output logic forced_crossover_disable_o,
   output logic legacy_detect_disable_o,
   output logic pair_swap_disable_o,
   output logic polarity_fix_disable_o,
   output logic parallel_detect_honour_o,
   output logic pulse_shaping_disable_o,
   output logic next_page_manual_o
);
   logic [15:0] addr_r;
   logic [15:0] addr_nxt;
   logic [15:0] bypass_r;
   logic [15:0] bypass_nxt;
   logic [5:0] fast_flags_r;
   logic [5:0] fast_flags_nxt;
   logic [6:0] gig_flags_r;
   logic [6:0] gig_flags_nxt;
   logic [15:0] rdata_r;
   logic [15:0] rdata_nxt;
   logic [7:0] rx_cnt;
   logic [7:0] fc_cnt;
   logic [7:0] drop_cnt;
   logic win_wr;
   logic win_rd;
   logic fn_addr;
   logic rd_fast;
   logic rd_gig;
   mmd_function_t fn;

   assign fn = mmd_function_t'(mmd_function_i);
   assign fn_addr = (fn == FN_ADDRESS);
   assign win_wr = reg_wr_i && reg_addr_i == `ADDR_WINDOW;
   assign win_rd = reg_rd_i && reg_addr_i == `ADDR_WINDOW;
   assign rd_fast = reg_rd_i && reg_addr_i == `ADDR_FAST_STAT;
   assign rd_gig = reg_rd_i && reg_addr_i == `ADDR_GIG_STAT;

   // Window: address store or data pass to MMD
   always_comb
   begin
      addr_nxt = addr_r;
      if (win_wr && fn_addr)
         addr_nxt = reg_wdata_i;
      else if (!fn_addr)
      begin
         unique case (fn)
            FN_DATA_INC_RW:
               if (win_wr || win_rd)
                  addr_nxt = addr_r + 16'h0001;
            FN_DATA_INC_W:
               if (win_wr)
                  addr_nxt = addr_r + 16'h0001;
            default:
               addr_nxt = addr_r;
         endcase
      end
   end
   assign mmd_wr_o = win_wr && !fn_addr;
   assign mmd_rd_o = win_rd && !fn_addr;
   assign mmd_dev_o = mmd_device_select_i;
   assign mmd_addr_o = addr_r;
   assign mmd_wdata_o = reg_wdata_i;

   // Bypass control with sticky subset on soft reset
   always_comb
   begin
      bypass_nxt = bypass_r;
      if (soft_reset_i)
      begin
         if (sticky_reset_enable_i)
            bypass_nxt = (bypass_r & `BYPASS_STICKY_MASK)
               | (`BYPASS_RESET & ~`BYPASS_STICKY_MASK);
         else
            bypass_nxt = `BYPASS_RESET;
      end
      else if (reg_wr_i && reg_addr_i == `ADDR_BYPASS)
         bypass_nxt = reg_wdata_i & `BYPASS_WMASK;
   end

   // Latched error flags; an event beats the clearing read
   always_comb
   begin
      fast_flags_nxt = (rd_fast ? 6'h00 : fast_flags_r) | fast_events_i;
      gig_flags_nxt = (rd_gig ? 7'h00 : gig_flags_r) | gig_events_i;
   end

   // Read data mux, registered
   always_comb
   begin
      rdata_nxt = 16'h0000;
      unique case (reg_addr_i)
         `ADDR_WINDOW:
            rdata_nxt = fn_addr ? addr_r : mmd_rdata_i;
         `ADDR_GIG_CAP:
            rdata_nxt = `GIG_CAP_VALUE;
         `ADDR_FAST_STAT:
         begin
            rdata_nxt[14:13] = fast_flags_r[5:4];
            rdata_nxt[11:8] = fast_flags_r[3:0];
            rdata_nxt[`FAST_LOCK_BIT] = fast_lock_i;
            rdata_nxt[`FAST_LINK_BIT] = fast_link_i;
         end
         `ADDR_GIG_STAT:
         begin
            rdata_nxt[14:13] = gig_flags_r[6:5];
            rdata_nxt[11:7] = gig_flags_r[4:0];
            rdata_nxt[`GIG_LOCK_BIT] = gig_lock_i;
            rdata_nxt[`GIG_LINK_BIT] = gig_link_i;
            rdata_nxt[`GIG_LEGACY_BIT] = legacy_partner_i;
            rdata_nxt[`GIG_XOVER_BIT] = crossover_error_i;
         end
         `ADDR_BYPASS:
            rdata_nxt = bypass_r;
         `ADDR_RX_ERR_CNT:
            rdata_nxt[7:0] = rx_cnt;
         `ADDR_FALSE_CAR_CNT:
            rdata_nxt[7:0] = fc_cnt;
         `ADDR_LINK_DROP_CNT:
            rdata_nxt[7:0] = drop_cnt;
         default:
            rdata_nxt = 16'h0000;
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         addr_r <= 16'h0000;
         bypass_r <= `BYPASS_RESET;
         fast_flags_r <= 6'h00;
         gig_flags_r <= 7'h00;
         rdata_r <= 16'h0000;
      end
      else
      begin
         addr_r <= addr_nxt;
         bypass_r <= bypass_nxt;
         fast_flags_r <= fast_flags_nxt;
         gig_flags_r <= gig_flags_nxt;
         rdata_r <= rdata_nxt;
      end
   end
   assign reg_rdata_o = rdata_r;

   assign transmit_disable_o = bypass_r[15];
   assign path_bypass_o = bypass_r[14:10];
   assign link_fail_inhibit_bypass_o = bypass_r[9];
   assign forced_crossover_disable_o = bypass_r[7];
   assign legacy_detect_disable_o = bypass_r[6];
   assign pair_swap_disable_o = bypass_r[5];
   assign polarity_fix_disable_o = bypass_r[4];
   assign parallel_detect_honour_o = bypass_r[3];
   assign pulse_shaping_disable_o = bypass_r[2];
   assign next_page_manual_o = bypass_r[1];

   sat_read_counter u_rx_cnt (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .event_i(rx_error_i),
      .read_clear_i(reg_rd_i && reg_addr_i == `ADDR_RX_ERR_CNT),
      .count_o(rx_cnt)
   );
   sat_read_counter u_fc_cnt (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .event_i(false_carrier_i),
      .read_clear_i(reg_rd_i && reg_addr_i == `ADDR_FALSE_CAR_CNT),
      .count_o(fc_cnt)
   );
   sat_read_counter u_drop_cnt (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .event_i(link_drop_i),
      .read_clear_i(reg_rd_i && reg_addr_i == `ADDR_LINK_DROP_CNT),
      .count_o(drop_cnt)
   );
endmodule : phy_status_bypass_counter_regs
`default_nettype wire

// ### tb/phy_regs_assertions.sv
`default_nettype none
module phy_regs_assertions (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic soft_reset_i,
   input wire logic [4:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [15:0] reg_wdata_i,
   input wire logic [15:0] reg_rdata_o,
   input wire logic [1:0] mmd_function_i,
   input wire logic mmd_wr_o,
   input wire logic mmd_rd_o,
   input wire logic [15:0] mmd_addr_o,
   input wire logic [15:0] mmd_rdata_i,
   input wire logic fast_lock_i,
   input wire logic gig_link_i,
   input wire logic transmit_disable_o
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);
   wire win = reg_addr_i == 5'h0E;
   property p_wrd; reg_rd_i && win && mmd_function_i != 0 |=> reg_rdata_o == $past(mmd_rdata_i);
   endproperty
   property p_adr; reg_wr_i && win && mmd_function_i == 0 |-> !mmd_wr_o; endproperty
   property p_inc; reg_wr_i && win && mmd_function_i == 2 |=>
      mmd_addr_o == 16'($past(mmd_addr_o) + 16'h0001);
   endproperty
   property p_mrd; reg_rd_i && win && mmd_function_i != 0 |-> mmd_rd_o; endproperty
   property p_cap; reg_rd_i && reg_addr_i == 5'h0F |=> reg_rdata_o == 16'h3000; endproperty
   property p_fst; reg_rd_i && reg_addr_i == 5'h10 |=> reg_rdata_o[15] == $past(fast_lock_i);
   endproperty
   property p_gig; reg_rd_i && reg_addr_i == 5'h11 |=> reg_rdata_o[12] == $past(gig_link_i);
   endproperty
   property p_txd; reg_wr_i && reg_addr_i == 5'h12 && reg_wdata_i[15] && !soft_reset_i |=>
      transmit_disable_o; endproperty
   property p_rsv; reg_rd_i && reg_addr_i == 5'h13 |=> reg_rdata_o[15:8] == 8'h00; endproperty
   a_wrd: assert property (p_wrd) else $error("window read data wrong");
   a_adr: assert property (p_adr) else $error("address write strobed");
   a_inc: assert property (p_inc) else $error("no increment");
   a_mrd: assert property (p_mrd) else $error("window read not strobed");
   a_cap: assert property (p_cap) else $error("capability wrong");
   a_fst: assert property (p_fst) else $error("fast lock wrong");
   a_gig: assert property (p_gig) else $error("gig link wrong");
   a_txd: assert property (p_txd) else $error("tx disable off");
   a_rsv: assert property (p_rsv) else $error("reserved set");
   c_inc: cover property (reg_wr_i && win && mmd_function_i == 2);
   c_sat: cover property (reg_rd_i ##1 reg_rdata_o == 16'h00FF);
   c_srs: cover property (soft_reset_i);
endmodule : phy_regs_assertions
`default_nettype wire

// ### tb/mmd_model.sv
`default_nettype none
module mmd_model (
   input wire logic clk_i,
   input wire logic wr_i,
   input wire logic [15:0] addr_i,
   input wire logic [15:0] wdata_i,
   output logic [15:0] rdata_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] mem [16];
   always_ff @(posedge clk_i) if (wr_i) mem[addr_i[3:0]] <= wdata_i;
   assign rdata_o = mem[addr_i[3:0]];
endmodule : mmd_model
`default_nettype wire

// ### tb/tb_top.sv
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_i, reset_i, soft_reset_i, sticky_reset_enable_i, reg_wr_i, reg_rd_i, mmd_wr_o;
   logic [4:0] reg_addr_i, mmd_device_select_i, mmd_dev_o, path_bypass_o;
   logic [15:0] reg_wdata_i, reg_rdata_o, mmd_addr_o, mmd_wdata_o, mmd_rdata_i, v;
   logic [1:0] mmd_function_i;
   logic [5:0] fast_events_i;
   logic [6:0] gig_events_i;
   logic mmd_rd_o, fast_lock_i, fast_link_i, gig_lock_i, gig_link_i, legacy_partner_i,
      crossover_error_i, rx_error_i, false_carrier_i, link_drop_i, transmit_disable_o,
      link_fail_inhibit_bypass_o, forced_crossover_disable_o, legacy_detect_disable_o,
      pair_swap_disable_o, polarity_fix_disable_o, parallel_detect_honour_o,
      pulse_shaping_disable_o, next_page_manual_o;
   int failures, tests_run, seed, n, m;
   phy_status_bypass_counter_regs dut (.*);
   mmd_model mdl (.clk_i, .wr_i(mmd_wr_o), .addr_i(mmd_addr_o), .wdata_i(mmd_wdata_o),
      .rdata_o(mmd_rdata_i));
   initial
   begin
      clk_i = 0;
      forever #5 clk_i = ~clk_i;
   end
   task chk(input logic [15:0] g, e);
      tests_run++;
      if (g !== e)
      begin
         failures++;
         $display("unexpected t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   task wr(input logic [4:0] a, input logic [15:0] d, input logic [1:0] f = 0);
      @(posedge clk_i);
      {reg_addr_i, reg_wdata_i, mmd_function_i, reg_wr_i} <= {a, d, f, 1'b1};
      @(posedge clk_i);
      reg_wr_i <= 0;
   endtask : wr
   task rd(input logic [4:0] a, input logic [15:0] e, input logic [1:0] f = 0);
      @(posedge clk_i);
      {reg_addr_i, mmd_function_i, reg_rd_i} <= {a, f, 1'b1};
      @(posedge clk_i);
      reg_rd_i <= 0;
      #1 chk(reg_rdata_o, e);
   endtask : rd
   function automatic logic [15:0] fexp(input logic [5:0] e);
      return {fast_lock_i, e[5:4], fast_link_i, e[3:0], 8'h00};
   endfunction : fexp
   function automatic logic [15:0] gexp(input logic [6:0] e);
      return {gig_lock_i, e[6:5], gig_link_i, e[4:0], legacy_partner_i, crossover_error_i, 5'h00};
   endfunction : gexp
   initial
   begin
      {seed, failures, tests_run} = {32'h5B11, 64'h0};
      {reset_i, soft_reset_i, sticky_reset_enable_i, reg_wr_i, reg_rd_i} = 5'h10;
      {reg_addr_i, reg_wdata_i, mmd_function_i, mmd_device_select_i} = 28'h0000003;
      {fast_lock_i, fast_link_i, gig_lock_i, gig_link_i, legacy_partner_i, crossover_error_i} = 0;
      {fast_events_i, gig_events_i, rx_error_i, false_carrier_i, link_drop_i} = 0;
      repeat (5) @(posedge clk_i);
      reset_i <= 0;
      rd(5'h12, 16'h0088);
      rd(5'h0F, 16'h3000);
      for (n = 0; n < 4; n++)
      begin
         v = $random(seed);
         wr(5'h12, v);
         rd(5'h12, v & 16'hFEFE);
         chk({transmit_disable_o, path_bypass_o, link_fail_inhibit_bypass_o, 1'b0,
            forced_crossover_disable_o, legacy_detect_disable_o, pair_swap_disable_o,
            polarity_fix_disable_o, parallel_detect_honour_o, pulse_shaping_disable_o,
            next_page_manual_o, 1'b0}, v & 16'hFEFE);
         @(posedge clk_i);
         {sticky_reset_enable_i, soft_reset_i} <= {n[0], 1'b1};
         @(posedge clk_i);
         soft_reset_i <= 0;
         rd(5'h12, n[0] ? v & 16'h00FA : 16'h0088);
      end
      $display("test bypass done");
      repeat (3)
      begin
         v = $random(seed);
         @(posedge clk_i);
         {fast_lock_i, fast_link_i, gig_lock_i, gig_link_i, legacy_partner_i} <= v[15:11];
         {crossover_error_i, fast_events_i, gig_events_i} <= {v[10], v[5:0], v[6:0]};
         @(posedge clk_i);
         {fast_events_i, gig_events_i} <= 0;
         rd(5'h10, fexp(v[5:0]));
         rd(5'h10, fexp(6'h00));
         rd(5'h11, gexp(v[6:0]));
         rd(5'h11, gexp(7'h00));
      end
      $display("test flags done");
      for (n = 0; n < 3; n++)
      begin
         m = n * 130 + 1 + ($random(seed) & 7);
         @(posedge clk_i);
         {link_drop_i, false_carrier_i, rx_error_i} <= 3'h1 << n;
         repeat (m) @(posedge clk_i);
         {link_drop_i, false_carrier_i, rx_error_i} <= 3'h0;
         rd(5'(19 + n), m > 255 ? 16'h00FF : 16'(m));
         rd(5'(19 + n), 16'h0000);
      end
      $display("test counters done");
      @(posedge clk_i);
      reset_i <= 1;
      repeat (2) @(posedge clk_i);
      reset_i <= 0;
      rd(5'h12, 16'h0088);
      $display("test mid reset done");
      v = $random(seed);
      wr(5'h0E, 16'h0005);
      wr(5'h0E, v, 2'h2);
      @(posedge clk_i);
      #1 chk(mmd_addr_o, 16'h0006);
      chk({11'h000, mmd_dev_o}, 16'h0003);
      wr(5'h0E, ~v, 2'h3);
      wr(5'h0E, 16'h0005);
      rd(5'h0E, v, 2'h2);
      rd(5'h0E, ~v, 2'h3);
      rd(5'h0E, ~v, 2'h1);
      chk(mmd_addr_o, 16'h0006);
      rd(5'h1F, 16'h0000);
      $display("test window done");
      summarize;
   end
   initial
   begin
      #500000;
      failures++;
      summarize;
   end
   task summarize;
      $display("counts tests_run=%0d failures=%0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : summarize
endmodule : tb_top
bind phy_status_bypass_counter_regs phy_regs_assertions chk_u (.*);
`default_nettype wire
